// ===== common/fault_mon_pkg.sv
// constants, fault indices and codes for the engine fault monitor
package fault_mon_pkg;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int MS_IN_PS      = 1000000000;
	localparam int CYC_PER_MS    = MS_IN_PS / CLK_PERIOD_PS;
	localparam int MS_PER_TICK   = 1;
	localparam int INTERVAL_MS   = 100;
	localparam int INTERVAL_TICKS = INTERVAL_MS / MS_PER_TICK;

	// timers counted in millisecond ticks
	localparam int NT        = 5;
	localparam int T_OFF     = 0;
	localparam int T_UNLOCK  = 1;
	localparam int T_NOLOCK  = 2;
	localparam int T_DUTY    = 3;
	localparam int T_MOTOR   = 4;
	localparam int TW        = 14;
	localparam int OFF_MS    = 3000;
	localparam int UNLOCK_MS = 200;
	localparam int NOLOCK_MS = 10000;
	localparam int DUTY_MS   = 200;
	localparam int MOTOR_MS  = 200;
	localparam logic [TW-1:0] TMR_LIM [NT] = '{
		TW'(OFF_MS / MS_PER_TICK), TW'(UNLOCK_MS / MS_PER_TICK), TW'(NOLOCK_MS / MS_PER_TICK),
		TW'(DUTY_MS / MS_PER_TICK), TW'(MOTOR_MS / MS_PER_TICK)};

	localparam logic [2:0]  SYNC_MISS_MAX = 3'h5;
	localparam logic [2:0]  GATE_MM_MAX   = 3'h5;
	localparam logic [3:0]  TD_BAD_RUN    = 4'hA;
	localparam logic [12:0] TD_LOW_MV     = 13'h00C8;
	localparam logic [12:0] TD_HIGH_MV    = 13'h0FA0;
	localparam logic [6:0]  DUTY_LIMIT_PC = 7'h32;
	localparam logic [11:0] MOTOR_LIM_MA  = 12'h3E8;

	// fault indices into the sticky vector
	localparam int NF   = 13;
	localparam int F202 = 0;
	localparam int F203 = 1;
	localparam int F204 = 2;
	localparam int F220 = 3;
	localparam int F230 = 4;
	localparam int F302 = 5;
	localparam int F390 = 6;
	localparam int F391 = 7;
	localparam int F392 = 8;
	localparam int F401 = 9;
	localparam int F402 = 10;
	localparam int F411 = 11;
	localparam int F490 = 12;
	localparam logic [9:0] FAULT_CODE [NF] = '{
		10'h0CA, 10'h0CB, 10'h0CC, 10'h0DC, 10'h0E6, 10'h12E, 10'h186,
		10'h187, 10'h188, 10'h191, 10'h192, 10'h19B, 10'h1EA};
endpackage

// ===== common/tick_if.sv
// millisecond and interval ticks passed from the timebase to the monitor
interface tick_if;
	logic ms_tick;
	logic interval_tick;
	modport src (output ms_tick, output interval_tick);
	modport dst (input ms_tick, input interval_tick);
endinterface

// ===== src/fault_timebase.sv
// millisecond and 100 ms interval tick generator
module fault_timebase
	import fault_mon_pkg::*;
#(
	parameter int CYC_MS = CYC_PER_MS
) (
	input  wire logic i_clk,
	input  wire logic i_rst,
	tick_if.src       tick
);
	typedef struct packed {
		logic [31:0] cyc;
		logic [6:0]  ms;
		logic        ms_tick;
		logic        iv_tick;
	} tb_state_type;

	tb_state_type s_q;
	tb_state_type s_d;

	always_comb begin
		s_d = s_q;
		s_d.ms_tick = 1'b0;
		s_d.iv_tick = 1'b0;
		if (s_q.cyc == 32'(CYC_MS - 1)) begin
			s_d.cyc = '0;
			s_d.ms_tick = 1'b1;
			if (s_q.ms == 7'(INTERVAL_TICKS - 1)) begin
				s_d.ms = '0;
				s_d.iv_tick = 1'b1;
			end else begin
				s_d.ms = s_q.ms + 7'h01;
			end
		end else begin
			s_d.cyc = s_q.cyc + 32'h1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick.ms_tick       = s_q.ms_tick;
	assign tick.interval_tick = s_q.iv_tick;

	a_tick_period: assert property (@(posedge i_clk) disable iff (i_rst)
		s_q.ms_tick |=> !s_q.ms_tick)
		else $error("ms tick lasted more than one cycle");
endmodule

// ===== src/print_engine_fault_monitor.sv
// engine fault supervisor raising latched service-call codes
module print_engine_fault_monitor
	import fault_mon_pkg::*;
#(
	parameter int CYC_MS = CYC_PER_MS
) (
	input  wire logic        I_CLK,
	input  wire logic        I_RST,
	input  wire logic        I_SCAN_MOTOR_ON,
	input  wire logic        I_SCANNER_READY_INDICATION,
	input  wire logic        I_SYNC_ENABLE,
	input  wire logic        I_LINE_SYNC,
	input  wire logic        I_WRITE_START,
	input  wire logic        I_DRUM_MM_TICK,
	input  wire logic        I_WRITE_GATE,
	input  wire logic        I_CHARGE_LEAK,
	input  wire logic        I_DEV_BIAS_LEAK,
	input  wire logic        I_COPYING,
	input  wire logic        I_TD_VALID,
	input  wire logic [12:0] I_TD_MV,
	input  wire logic        I_TD_INIT_DONE,
	input  wire logic        I_TD_INIT_OK,
	input  wire logic        I_XFER_ACTIVE,
	input  wire logic        I_XFER_STAGE2,
	input  wire logic        I_XFER_LEAK,
	input  wire logic        I_XFER_FEEDBACK,
	input  wire logic [6:0]  I_DISCHARGE_DUTY,
	input  wire logic [11:0] I_TONER_MOTOR_MA,
	input  wire logic        I_CLEAR,
	output logic             O_FAULT,
	output logic [NF-1:0]    O_FAULT_VEC,
	output logic [9:0]       O_FAULT_CODE
);
	typedef struct packed {
		logic [NT-1:0][TW-1:0] tmr;
		logic                  motor_q;
		logic                  off_arm;
		logic                  locked;
		logic [2:0]            miss;
		logic                  sync_seen;
		logic                  gate_arm;
		logic [2:0]            mm;
		logic [3:0]            td_cnt;
		logic [NF-1:0]         flt;
		logic [9:0]            code;
	} mon_state_type;

	mon_state_type s_q;
	mon_state_type s_d;
	logic [NT-1:0] tc;
	logic [NF-1:0] ev;
	logic          td_bad;
	logic          xfer_bad;

	tick_if tick ();

	fault_timebase #(
		.CYC_MS (CYC_MS)
	) u_timebase (
		.i_clk (I_CLK),
		.i_rst (I_RST),
		.tick  (tick)
	);

	always_comb begin
		tc[T_OFF]    = s_q.off_arm & I_SCANNER_READY_INDICATION;
		tc[T_UNLOCK] = I_SCAN_MOTOR_ON & s_q.locked & ~I_SCANNER_READY_INDICATION;
		tc[T_NOLOCK] = I_SCAN_MOTOR_ON & ~s_q.locked & ~I_SCANNER_READY_INDICATION;
		tc[T_DUTY]   = I_DISCHARGE_DUTY >= DUTY_LIMIT_PC;
		tc[T_MOTOR]  = I_TONER_MOTOR_MA >= MOTOR_LIM_MA;
		td_bad   = (I_TD_MV < TD_LOW_MV) || (I_TD_MV > TD_HIGH_MV);
		xfer_bad = I_XFER_ACTIVE & (I_XFER_LEAK | ~I_XFER_FEEDBACK);
	end

	always_comb begin
		s_d = s_q;
		ev  = '0;
		s_d.motor_q = I_SCAN_MOTOR_ON;
		// timers saturate at their limit and restart when the condition drops
		for (int k = 0; k < NT; k++) begin
			if (!tc[k]) begin
				s_d.tmr[k] = '0;
			end else if (tick.ms_tick && s_q.tmr[k] != TMR_LIM[k]) begin
				s_d.tmr[k] = s_q.tmr[k] + TW'(1);
			end
		end
		ev[F203] = tc[T_OFF] && tick.ms_tick && s_q.tmr[T_OFF] == TMR_LIM[T_OFF] - TW'(1);
		ev[F204] = tc[T_UNLOCK] && tick.ms_tick && s_q.tmr[T_UNLOCK] == TMR_LIM[T_UNLOCK] - TW'(1);
		ev[F202] = tc[T_NOLOCK] && tick.ms_tick && s_q.tmr[T_NOLOCK] == TMR_LIM[T_NOLOCK] - TW'(1);
		ev[F411] = tc[T_DUTY] && tick.ms_tick && s_q.tmr[T_DUTY] == TMR_LIM[T_DUTY] - TW'(1);
		ev[F490] = tc[T_MOTOR] && tick.ms_tick && s_q.tmr[T_MOTOR] == TMR_LIM[T_MOTOR] - TW'(1);
		// scanner command edges
		if (s_q.motor_q && !I_SCAN_MOTOR_ON) begin
			s_d.off_arm = 1'b1;
		end else if (I_SCAN_MOTOR_ON || !I_SCANNER_READY_INDICATION) begin
			s_d.off_arm = 1'b0;
		end
		if (!I_SCAN_MOTOR_ON) begin
			s_d.locked = 1'b0;
		end else if (I_SCANNER_READY_INDICATION) begin
			s_d.locked = 1'b1;
		end
		// line sync per interval
		if (!I_SYNC_ENABLE) begin
			s_d.miss = '0;
			s_d.sync_seen = 1'b0;
		end else if (tick.interval_tick) begin
			s_d.sync_seen = I_LINE_SYNC;
			if (s_q.sync_seen || I_LINE_SYNC) begin
				s_d.miss = '0;
			end else if (s_q.miss == SYNC_MISS_MAX) begin
				ev[F220] = 1'b1;
			end else begin
				s_d.miss = s_q.miss + 3'h1;
			end
		end else if (I_LINE_SYNC) begin
			s_d.sync_seen = 1'b1;
		end
		// write gate against drum travel
		if (I_WRITE_START) begin
			s_d.gate_arm = 1'b1;
			s_d.mm = '0;
		end else if (s_q.gate_arm && !I_WRITE_GATE) begin
			s_d.gate_arm = 1'b0;
		end else if (s_q.gate_arm && I_DRUM_MM_TICK) begin
			if (s_q.mm == GATE_MM_MAX - 3'h1) begin
				ev[F230] = 1'b1;
				s_d.gate_arm = 1'b0;
			end
			s_d.mm = s_q.mm + 3'h1;
		end
		// toner density run of bad samples
		if (!I_COPYING) begin
			s_d.td_cnt = '0;
		end else if (I_TD_VALID) begin
			if (!td_bad) begin
				s_d.td_cnt = '0;
			end else if (s_q.td_cnt == TD_BAD_RUN - 4'h1) begin
				ev[F390] = 1'b1;
				s_d.td_cnt = '0;
			end else begin
				s_d.td_cnt = s_q.td_cnt + 4'h1;
			end
		end
		ev[F302] = I_CHARGE_LEAK;
		ev[F391] = I_DEV_BIAS_LEAK;
		ev[F392] = I_TD_INIT_DONE & ~I_TD_INIT_OK;
		ev[F401] = xfer_bad & ~I_XFER_STAGE2;
		ev[F402] = xfer_bad & I_XFER_STAGE2;
		// sticky flags, a new event wins over the clear
		s_d.flt = (I_CLEAR ? '0 : s_q.flt) | ev;
		if (I_CLEAR) begin
			s_d.code = '0;
		end
		if ((I_CLEAR || s_q.flt == '0) && ev != '0) begin
			for (int f = NF - 1; f >= 0; f--) begin
				if (ev[f]) begin
					s_d.code = FAULT_CODE[f];
				end
			end
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign O_FAULT      = |s_q.flt;
	assign O_FAULT_VEC  = s_q.flt;
	assign O_FAULT_CODE = s_q.code;

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RST);

	a_off_timeout: assert property ($rose(s_q.flt[F203]) |-> $past(s_q.tmr[T_OFF]) == TW'(OFF_MS - 1))
		else $error("203 raised without full off timeout");
	a_unlock_run: assert property (tc[T_UNLOCK] && tick.ms_tick && s_q.tmr[T_UNLOCK] == TW'(UNLOCK_MS - 1)
		|=> s_q.flt[F204])
		else $error("204 not raised after unlock run");
	a_lock_missing: assert property ($rose(s_q.flt[F202]) |-> $past(s_q.tmr[T_NOLOCK]) == TW'(NOLOCK_MS - 1))
		else $error("202 raised early");
	a_sync_miss: assert property ($rose(s_q.flt[F220]) |-> $past(s_q.miss) == SYNC_MISS_MAX)
		else $error("220 raised at wrong miss count");
	a_gate_late: assert property ($rose(s_q.flt[F230]) |-> $past(s_q.gate_arm) && $past(I_WRITE_GATE))
		else $error("230 raised with gate low");
	a_charge_leak: assert property (I_CHARGE_LEAK |=> s_q.flt[F302])
		else $error("charge leak not latched");
	a_td_run: assert property ($rose(s_q.flt[F390]) |-> $past(s_q.td_cnt) == 4'h9 && $past(I_COPYING))
		else $error("390 raised at wrong run length");
	a_dev_leak: assert property (I_DEV_BIAS_LEAK |=> s_q.flt[F391])
		else $error("bias leak not latched");
	a_td_init: assert property (I_TD_INIT_DONE && !I_TD_INIT_OK |=> s_q.flt[F392])
		else $error("init failure not latched");
	a_xfer_first: assert property (xfer_bad && !I_XFER_STAGE2 |=> s_q.flt[F401])
		else $error("401 not latched");
	a_xfer_second: assert property ($rose(s_q.flt[F402]) |-> $past(xfer_bad && I_XFER_STAGE2))
		else $error("402 raised without cause");
	a_duty_hold: assert property ($rose(s_q.flt[F411]) |-> $past(s_q.tmr[T_DUTY]) == TW'(DUTY_MS - 1))
		else $error("411 raised early");
	a_motor_hold: assert property ($rose(s_q.flt[F490]) |-> $past(s_q.tmr[T_MOTOR]) == TW'(MOTOR_MS - 1))
		else $error("490 raised early");
	a_flags_sticky: assert property (!I_CLEAR |=> (s_q.flt & $past(s_q.flt)) == $past(s_q.flt))
		else $error("fault flag dropped without clear");
	a_timer_restart: assert property (!tc[T_DUTY] |=> s_q.tmr[T_DUTY] == '0)
		else $error("timer kept counting after condition cleared");

	c_off_fault: cover property ($rose(s_q.flt[F203]));
	c_sync_fault: cover property ($rose(s_q.flt[F220]));
	c_td_fault: cover property ($rose(s_q.flt[F390]));
	c_clear_set: cover property (I_CLEAR && ev != '0);
endmodule

// ===== sim/engine_partner.sv
// behavioural scanner motor and laser sync source facing the fault monitor
module engine_partner #(
	parameter int LOCK_CYC = 40
) (
	input  wire logic i_clk,
	input  wire logic i_motor_on,
	input  wire logic i_no_lock,
	input  wire logic i_hold_lock,
	input  wire logic i_drop_lock,
	input  wire logic i_dark,
	output logic      o_ready,
	output logic      o_line_sync
);
	timeunit 1ns;
	timeprecision 1ps;
	int spin_q = 0;
	int phase_q = 0;
	// lock comes some cycles after the on command
	always_ff @(posedge i_clk) begin
		spin_q <= !i_motor_on ? 0 : (spin_q < LOCK_CYC) ? spin_q + 1 : spin_q;
		phase_q <= (phase_q == 49) ? 0 : phase_q + 1;
	end
	// lock drops at once when off unless told to stick
	assign o_ready = i_motor_on ? (!i_no_lock && !i_drop_lock && spin_q == LOCK_CYC) : i_hold_lock;
	assign o_line_sync = o_ready && !i_dark && phase_q == 0;
endmodule

// ===== sim/print_engine_fault_monitor_tb.sv
// scenario bench for the engine fault monitor
module print_engine_fault_monitor_tb
	import fault_mon_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CYC = 4;
	logic I_CLK = 1'b0, I_RST = 1'b1, I_SCAN_MOTOR_ON = 1'b0, I_SYNC_ENABLE = 1'b0;
	logic I_WRITE_START = 1'b0, I_DRUM_MM_TICK = 1'b0, I_WRITE_GATE = 1'b0, I_CHARGE_LEAK = 1'b0;
	logic I_DEV_BIAS_LEAK = 1'b0, I_COPYING = 1'b0, I_TD_VALID = 1'b0, I_TD_INIT_DONE = 1'b0;
	logic I_TD_INIT_OK = 1'b1, I_XFER_ACTIVE = 1'b0, I_XFER_STAGE2 = 1'b0, I_XFER_LEAK = 1'b0;
	logic I_XFER_FEEDBACK = 1'b1, I_CLEAR = 1'b0, no_lock = 1'b0, hold_lock = 1'b0;
	logic drop_lock = 1'b0, dark = 1'b0;
	logic [12:0] I_TD_MV = 13'h0800;
	logic [6:0]  I_DISCHARGE_DUTY = 7'h00;
	logic [11:0] I_TONER_MOTOR_MA = 12'h000;
	logic        I_SCANNER_READY_INDICATION, I_LINE_SYNC, O_FAULT;
	logic [NF-1:0] O_FAULT_VEC;
	logic [9:0]  O_FAULT_CODE;
	int          bad_count = 0;
	int          num_checks = 0;

	print_engine_fault_monitor #(.CYC_MS(CYC)) uut (.I_CLK, .I_RST, .I_SCAN_MOTOR_ON,
		.I_SCANNER_READY_INDICATION, .I_SYNC_ENABLE, .I_LINE_SYNC, .I_WRITE_START, .I_DRUM_MM_TICK,
		.I_WRITE_GATE, .I_CHARGE_LEAK, .I_DEV_BIAS_LEAK, .I_COPYING, .I_TD_VALID, .I_TD_MV,
		.I_TD_INIT_DONE, .I_TD_INIT_OK, .I_XFER_ACTIVE, .I_XFER_STAGE2, .I_XFER_LEAK,
		.I_XFER_FEEDBACK, .I_DISCHARGE_DUTY, .I_TONER_MOTOR_MA, .I_CLEAR, .O_FAULT, .O_FAULT_VEC,
		.O_FAULT_CODE);
	engine_partner #(.LOCK_CYC(40)) pm (.i_clk(I_CLK), .i_motor_on(I_SCAN_MOTOR_ON),
		.i_no_lock(no_lock), .i_hold_lock(hold_lock), .i_drop_lock(drop_lock), .i_dark(dark),
		.o_ready(I_SCANNER_READY_INDICATION), .o_line_sync(I_LINE_SYNC));

	initial forever #2.5 I_CLK = ~I_CLK;

	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic cmp(input string n, input logic [12:0] e, input logic [12:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge I_CLK);
	endtask
	task automatic ms(input int n);
		cyc(n * CYC);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
		cyc(1);
	endtask
	task automatic none;
		cmp("vec", 13'h0000, O_FAULT_VEC);
	endtask
	task automatic clr;
		pulse(I_CLEAR);
		none();
		cmp("code", 13'h0000, {3'h0, O_FAULT_CODE});
	endtask
	task automatic one(input int b, input logic [9:0] c);
		cmp("vec", 13'h0001 << b, O_FAULT_VEC);
		cmp("code", {3'h0, c}, {3'h0, O_FAULT_CODE});
		cmp("fault", 13'h0001, {12'h000, O_FAULT});
		clr();
	endtask
	task automatic samp(input logic [12:0] v);
		I_TD_MV = v;
		pulse(I_TD_VALID);
	endtask

	task automatic t_leaks;
		pulse(I_CHARGE_LEAK);
		pulse(I_DEV_BIAS_LEAK);
		cyc(3);
		cmp("vec", 13'h00A0, O_FAULT_VEC);
		cmp("code", 13'h012E, {3'h0, O_FAULT_CODE});
		clr();
		pulse(I_DEV_BIAS_LEAK);
		one(F391, 10'h187);
		// clear and a new leak in one cycle: the new flag and its code survive
		pulse(I_DEV_BIAS_LEAK);
		I_CLEAR = 1'b1;
		I_CHARGE_LEAK = 1'b1;
		cyc(1);
		I_CLEAR = 1'b0;
		I_CHARGE_LEAK = 1'b0;
		cyc(1);
		one(F302, 10'h12E);
	endtask
	task automatic t_xfer;
		for (int k = 0; k < 4; k++) begin
			I_XFER_STAGE2 = k[0];
			I_XFER_LEAK = k[1];
			I_XFER_FEEDBACK = k[1];
			pulse(I_XFER_ACTIVE);
			I_XFER_LEAK = 1'b0;
			I_XFER_FEEDBACK = 1'b1;
			one(F401 + k % 2, k[0] ? 10'h192 : 10'h191);
		end
		pulse(I_XFER_ACTIVE);
		none();
	endtask
	task automatic t_init;
		pulse(I_TD_INIT_DONE);
		none();
		I_TD_INIT_OK = 1'b0;
		pulse(I_TD_INIT_DONE);
		I_TD_INIT_OK = 1'b1;
		one(F392, 10'h188);
	endtask
	task automatic t_density;
		I_COPYING = 1'b1;
		repeat (9) samp(13'h00C7);
		samp(13'h0FA0);
		samp(13'h00C8);
		repeat (9) samp(13'h0FA1);
		none();
		samp(13'h00C7);
		I_COPYING = 1'b0;
		one(F390, 10'h186);
	endtask
	task automatic t_gate;
		I_WRITE_GATE = 1'b1;
		pulse(I_WRITE_START);
		repeat (4) pulse(I_DRUM_MM_TICK);
		I_WRITE_GATE = 1'b0;
		repeat (3) pulse(I_DRUM_MM_TICK);
		none();
		I_WRITE_GATE = 1'b1;
		pulse(I_WRITE_START);
		repeat (4) pulse(I_DRUM_MM_TICK);
		none();
		pulse(I_DRUM_MM_TICK);
		I_WRITE_GATE = 1'b0;
		one(F230, 10'h0E6);
	endtask
	task automatic t_level;
		I_DISCHARGE_DUTY = 7'h31;
		ms(250);
		I_DISCHARGE_DUTY = 7'h32;
		ms(150);
		I_DISCHARGE_DUTY = 7'h00;
		ms(1);
		I_DISCHARGE_DUTY = 7'h64;
		ms(150);
		none();
		ms(48);
		none();
		ms(3);
		I_DISCHARGE_DUTY = 7'h00;
		one(F411, 10'h19B);
		I_TONER_MOTOR_MA = 12'h3E7;
		ms(250);
		I_TONER_MOTOR_MA = 12'h3E8;
		ms(198);
		none();
		ms(3);
		I_TONER_MOTOR_MA = 12'h000;
		one(F490, 10'h1EA);
	endtask
	task automatic t_sync;
		I_SCAN_MOTOR_ON = 1'b1;
		ms(20);
		I_SYNC_ENABLE = 1'b1;
		ms(300);
		dark = 1'b1;
		ms(590);
		none();
		ms(120);
		dark = 1'b0;
		I_SYNC_ENABLE = 1'b0;
		one(F220, 10'h0DC);
	endtask
	task automatic t_scan;
		drop_lock = 1'b1;
		ms(198);
		none();
		ms(3);
		drop_lock = 1'b0;
		one(F204, 10'h0CC);
		I_SCAN_MOTOR_ON = 1'b0;
		ms(3010);
		none();
		I_SCAN_MOTOR_ON = 1'b1;
		ms(20);
		hold_lock = 1'b1;
		I_SCAN_MOTOR_ON = 1'b0;
		ms(2998);
		none();
		ms(3);
		hold_lock = 1'b0;
		one(F203, 10'h0CB);
		no_lock = 1'b1;
		I_SCAN_MOTOR_ON = 1'b1;
		ms(9998);
		none();
		ms(3);
		I_SCAN_MOTOR_ON = 1'b0;
		no_lock = 1'b0;
		one(F202, 10'h0CA);
	endtask

	initial begin
		cyc(3);
		I_RST = 1'b0;
		cyc(1);
		clr();
		t_leaks();
		t_xfer();
		t_init();
		t_density();
		t_gate();
		t_level();
		t_sync();
		t_scan();
		test_done();
	end
	// run needs about 74000 cycles; limit at 90000 cycles
	initial begin
		#450000;
		bad_count++;
		$display("[FAIL] watchdog expected finish seen timeout");
		test_done();
	end
endmodule
